// ==== core/adcc_channel.sv ====
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module adcc_channel
  import adcc_pkg::*;
#(
  parameter int CHANNEL_INDEX = 0
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Converter core
  input  adcc_conv_t       conv_in,
  output logic      [3:0]  applied_input_select,
  // Interrupt controller
  output adcc_irq_t        irq_out,
  input  wire logic        irq_vector_ack
);

  // Elaboration check on the channel number
  if (CHANNEL_INDEX < 0 || CHANNEL_INDEX > 3) begin : g_bad_index
    $error("adcc_channel: CHANNEL_INDEX must be 0 to 3");
  end

  localparam bit HAS_SCAN = (CHANNEL_INDEX == 0);

  logic        ack_ff;
  logic [31:0] readdata_ff;
  logic [31:0] nxt_readdata;
  logic [3:0]  idx;
  logic        rd_take;
  logic        wr_fire;
  logic [3:0]  positive_input_select_ff;
  logic [1:0]  lvl_ff;
  adcc_cond_t  cond_ff;
  logic        flag_ff;
  logic [15:0] result_ff;
  logic [7:0]  high_temp_ff;
  logic [3:0]  offs_ff;
  logic [3:0]  cnt_ff;
  logic        signed_ff;
  adcc_res_t   res_ff;
  logic [15:0] thresh_ff;
  logic [3:0]  applied_ff;
  logic [3:0]  nxt_applied;
  logic [15:0] nxt_result;
  logic [15:0] cmp_val;
  logic        cmp_below;
  logic        cmp_above;
  logic        cond_met;
  logic        set_evt;
  logic        sw_clr;
  logic        scan_active;
  logic        scan_wr;

  // Places a 12-bit conversion into the 16-bit result pair
  function automatic logic [15:0] adcc_format(input logic [11:0] v,
                                              input adcc_res_t   res,
                                              input logic        sgn);
    logic [15:0] r;
    r = 16'h0000;
    unique case (res)
      ADCC_RES_LEFT12: r = {v[11:4], v[3:0], 4'h0};
      ADCC_RES_EIGHT:  r = {{8{sgn & v[7]}}, v[7:0]};
      default:         r = {{4{sgn & v[11]}}, v[11:8], v[7:0]};
    endcase
    return r;
  endfunction

  // Bus decode: one wait state per access
  assign idx             = avs_address[5:2];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign rd_take         = avs_read & ~ack_ff;
  assign wr_fire         = avs_write & ack_ff & avs_byteenable[0];
  assign avs_readdata    = readdata_ff;

  // Acknowledge toggles for one cycle after a request is seen
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
    end
  end

  // Read data multiplexer; unmapped indices read zero
  always_comb begin
    nxt_readdata = 32'h0000_0000;
    unique case (idx)
      ADCC_IDX_MUXCTRL: nxt_readdata[7:0] = {1'b0, positive_input_select_ff, 3'h0};
      ADCC_IDX_INTCTRL: nxt_readdata[7:0] = {4'h0, cond_ff, lvl_ff};
      ADCC_IDX_FLAG:    nxt_readdata[7:0] = {7'h00, flag_ff};
      ADCC_IDX_CHAN_RESULT_LOW:    nxt_readdata[7:0] = result_ff[7:0];
      ADCC_IDX_CHAN_RESULT_HIGH:    nxt_readdata[7:0] = high_temp_ff;
      ADCC_IDX_SCAN:    nxt_readdata[7:0] = {offs_ff, cnt_ff};
      ADCC_IDX_CONFIG:  nxt_readdata[7:0] = {5'h00, res_ff, signed_ff};
      ADCC_IDX_THRESH:  nxt_readdata[15:0] = thresh_ff;
      default:          nxt_readdata = 32'h0000_0000;
    endcase
  end

  // Read data captured ahead of the acknowledge edge and held
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      readdata_ff <= 32'h0000_0000;
    end else if (rd_take) begin
      readdata_ff <= nxt_readdata;
    end
  end

  // High byte snapshot taken when the low byte is read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      high_temp_ff <= ADCC_RST_BYTE;
    end else if (rd_take && idx == ADCC_IDX_CHAN_RESULT_LOW) begin
      high_temp_ff <= result_ff[15:8];
    end
  end

  // Positive input select
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      positive_input_select_ff <= ADCC_RST_BYTE[3:0];
    end else if (wr_fire && idx == ADCC_IDX_MUXCTRL) begin
      positive_input_select_ff <= avs_writedata[ADCC_POSITIVE_INPUT_SELECT_LSB +: 4];
    end
  end

  // Interrupt control: level and flag condition
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lvl_ff  <= ADCC_RST_BYTE[1:0];
      cond_ff <= ADCC_COND_COMPLETE;
    end else if (wr_fire && idx == ADCC_IDX_INTCTRL) begin
      lvl_ff  <= avs_writedata[ADCC_LVL_LSB +: 2];
      cond_ff <= adcc_cond_t'(avs_writedata[ADCC_MODE_LSB +: 2]);
    end
  end

  // Conversion mode, result layout and compare threshold
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      signed_ff <= 1'b0;
      res_ff    <= ADCC_RES_RIGHT12;
      thresh_ff <= ADCC_RST_THRESH;
    end else if (avs_write && ack_ff) begin
      if (avs_byteenable[0] && idx == ADCC_IDX_CONFIG) begin
        signed_ff <= avs_writedata[ADCC_SIGNED_BIT];
        res_ff    <= adcc_res_t'(avs_writedata[ADCC_RES_LSB +: 2]);
      end
      if (idx == ADCC_IDX_THRESH) begin
        if (avs_byteenable[0]) begin
          thresh_ff[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          thresh_ff[15:8] <= avs_writedata[15:8];
        end
      end
    end
  end

  // Compare on the right-adjusted value, or the 8-bit value in 8-bit mode, signed when the mode is signed
  always_comb begin
    nxt_result = adcc_format(conv_in.conversion_value, res_ff, signed_ff);
    cmp_val    = adcc_format(conv_in.conversion_value,
                             (res_ff == ADCC_RES_EIGHT) ? ADCC_RES_EIGHT : ADCC_RES_RIGHT12,
                             signed_ff);
    if (signed_ff) begin
      cmp_below = $signed(cmp_val) < $signed(thresh_ff);
      cmp_above = $signed(cmp_val) > $signed(thresh_ff);
    end else begin
      cmp_below = cmp_val < thresh_ff;
      cmp_above = cmp_val > thresh_ff;
    end
    unique case (cond_ff)
      ADCC_COND_COMPLETE: cond_met = 1'b1;
      ADCC_COND_BELOW:    cond_met = cmp_below;
      ADCC_COND_ABOVE:    cond_met = cmp_above;
      default:            cond_met = 1'b0;
    endcase
  end

  assign set_evt = conv_in.done & cond_met;
  assign sw_clr  = (wr_fire && idx == ADCC_IDX_FLAG && avs_writedata[ADCC_FLAG_BIT])
                   || irq_vector_ack;

  // Result pair loads on every finished conversion
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_ff <= ADCC_RST_RESULT;
    end else if (conv_in.done) begin
      result_ff <= nxt_result;
    end
  end

  // Completion flag: a set beats a clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flag_ff <= 1'b0;
    end else if (set_evt) begin
      flag_ff <= 1'b1;
    end else if (sw_clr) begin
      flag_ff <= 1'b0;
    end
  end

  // Request gated by a nonzero level, carried with the level in one driver
  assign irq_out = '{req: flag_ff & (lvl_ff != 2'h0), irq_priority_level: lvl_ff};

  // Scan sequencer; absent channels hold zero
  assign scan_active = (cnt_ff != 4'h0);
  assign scan_wr     = wr_fire && idx == ADCC_IDX_SCAN && HAS_SCAN;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      offs_ff <= ADCC_RST_BYTE[7:4];
      cnt_ff  <= ADCC_RST_BYTE[3:0];
    end else if (scan_wr) begin
      offs_ff <= avs_writedata[ADCC_OFFS_LSB +: 4];
      cnt_ff  <= avs_writedata[ADCC_CNT_LSB +: 4];
    end else if (conv_in.done && scan_active && HAS_SCAN) begin
      if (offs_ff == cnt_ff) begin
        offs_ff <= 4'h0;
      end else begin
        offs_ff <= offs_ff + 4'h1;
      end
    end
  end

  // Applied select, registered
  assign nxt_applied = scan_active ? (positive_input_select_ff + offs_ff) : positive_input_select_ff;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      applied_ff <= 4'h0;
    end else begin
      applied_ff <= nxt_applied;
    end
  end

  assign applied_input_select = applied_ff;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_flag_on_done: assert property (conv_in.done && cond_ff == ADCC_COND_COMPLETE
                                   |=> flag_ff)
    else $error("flag not set after complete");
  a_cmp_gated: assert property (conv_in.done && cond_ff != ADCC_COND_COMPLETE && !cond_met
                                && !flag_ff |=> !flag_ff)
    else $error("flag set without compare match");
  a_ack_clears: assert property (irq_vector_ack && !set_evt |=> !flag_ff)
    else $error("vector ack did not clear flag");
  a_w1c_clears: assert property (avs_write && ack_ff && avs_byteenable[0]
                                 && idx == ADCC_IDX_FLAG && avs_writedata[0]
                                 && !set_evt |=> !flag_ff)
    else $error("write one did not clear flag");
  a_w0_keeps: assert property (flag_ff && !irq_vector_ack && !(wr_fire && idx == ADCC_IDX_FLAG
                               && avs_writedata[0]) |=> flag_ff)
    else $error("flag lost without clear");
  a_set_wins: assert property (set_evt && sw_clr |=> flag_ff)
    else $error("clear beat set");
  a_irq_follows: assert property (set_evt && lvl_ff != 2'h0
                                  && !(wr_fire && idx == ADCC_IDX_INTCTRL)
                                  |=> irq_out.req && irq_out.irq_priority_level == $past(lvl_ff))
    else $error("request does not follow flag");
  a_result_sync: assert property ($rose(flag_ff) |-> result_ff == $past(nxt_result))
    else $error("result not updated with flag");
  a_left_layout: assert property (conv_in.done && res_ff == ADCC_RES_LEFT12
                                  |=> result_ff == {$past(conv_in.conversion_value), 4'h0})
    else $error("left layout wrong");
  a_right_ext: assert property (conv_in.done && res_ff == ADCC_RES_RIGHT12
                                |=> result_ff[15:12] == {4{$past(signed_ff)
                                    & $past(conv_in.conversion_value[11])}})
    else $error("right extension wrong");
  a_eight_ext: assert property (conv_in.done && res_ff == ADCC_RES_EIGHT
                                |=> result_ff[15:8] == {8{$past(signed_ff)
                                    & $past(conv_in.conversion_value[7])}})
    else $error("eight-bit extension wrong");
  a_scan_wrap: assert property (conv_in.done && scan_active && offs_ff == cnt_ff && !scan_wr
                                |=> offs_ff == 4'h0)
    else $error("scan offset did not wrap");
  a_scan_idle: assert property (!scan_active && !scan_wr |=> offs_ff == $past(offs_ff))
    else $error("offset moved while scan idle");
  a_applied_sel: assert property (scan_active ##1 1'b1 |-> applied_input_select
                                  == 4'($past(positive_input_select_ff) + $past(offs_ff)))
    else $error("applied select wrong");
  a_no_scan: assert property (!HAS_SCAN |-> cnt_ff == 4'h0 && offs_ff == 4'h0)
    else $error("scan present on other channel");

  c_compare_hit: cover property (conv_in.done && cond_ff == ADCC_COND_ABOVE && cond_met);
  c_scan_wrap: cover property (conv_in.done && scan_active && offs_ff == cnt_ff);
  c_set_and_clr: cover property (set_evt && sw_clr);
  c_pair_read: cover property (rd_take && idx == ADCC_IDX_CHAN_RESULT_LOW ##[1:20] rd_take
                               && idx == ADCC_IDX_CHAN_RESULT_HIGH);

endmodule // adcc_channel

// ==== core/adcc_pkg.sv ====
// Functional notes
// - Two-bit priority level field enables the channel request; nonzero enables at that level.
// - With the request enabled, the request follows the channel completion flag.
// - In complete mode the flag in bit 0 sets when a conversion finishes.
// - In compare modes the flag sets only when the compare condition holds.
// - The flag clears automatically when the channel interrupt vector executes.
// - Writing one to the flag bit clears it; writing zero leaves it unchanged.
// - Signed results are two's complement with the top result bit as sign.
// - Low and high result bytes form one 16-bit value read via a latched pair.
// - Left-adjusted 12-bit mode puts result bits 11..4 in the high byte.
// - Left-adjusted mode puts bits 3..0 in the low byte upper nibble; rest zero.
// - Right-adjusted 12-bit mode puts bits 11..8 in the high byte lower nibble.
// - Right-adjusted upper high nibble copies bit 11 when signed, else zero.
// - In 8-bit mode the high byte copies bit 7 when signed, else zero.
// - In 8-bit and right-adjusted modes the low byte holds bits 7..0.
// - Scanning is active while the scan count is nonzero, inactive when zero.
// - The scan register exists only on channel zero.
// - While scanning the applied positive select is programmed select plus offset.
// - Each conversion increments the offset; offset equal to count wraps to zero.
// - A scan covers count plus one consecutive positive selections.
// - Flag condition select: 00 complete, 01 below, 11 above, 10 reserved.
package adcc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] ADCC_IDX_MUXCTRL = 4'h1;
  localparam logic [3:0] ADCC_IDX_INTCTRL = 4'h2;
  localparam logic [3:0] ADCC_IDX_FLAG    = 4'h3;
  localparam logic [3:0] ADCC_IDX_CHAN_RESULT_LOW    = 4'h4;
  localparam logic [3:0] ADCC_IDX_CHAN_RESULT_HIGH    = 4'h5;
  localparam logic [3:0] ADCC_IDX_SCAN    = 4'h6;
  localparam logic [3:0] ADCC_IDX_CONFIG  = 4'h8;
  localparam logic [3:0] ADCC_IDX_THRESH  = 4'h9;

  // Field positions
  localparam int ADCC_POSITIVE_INPUT_SELECT_LSB = 3;
  localparam int ADCC_LVL_LSB    = 0;
  localparam int ADCC_MODE_LSB   = 2;
  localparam int ADCC_FLAG_BIT   = 0;
  localparam int ADCC_OFFS_LSB   = 4;
  localparam int ADCC_CNT_LSB    = 0;
  localparam int ADCC_SIGNED_BIT = 0;
  localparam int ADCC_RES_LSB    = 1;

  // Reset values
  localparam logic [7:0]  ADCC_RST_BYTE   = 8'h00;
  localparam logic [15:0] ADCC_RST_RESULT = 16'h0000;
  localparam logic [15:0] ADCC_RST_THRESH = 16'h0000;

  // Flag condition select codes
  typedef enum logic [1:0] {
    ADCC_COND_COMPLETE = 2'h0,
    ADCC_COND_BELOW    = 2'h1,
    ADCC_COND_RSVD     = 2'h2,
    ADCC_COND_ABOVE    = 2'h3
  } adcc_cond_t;

  // Result layout codes
  typedef enum logic [1:0] {
    ADCC_RES_RIGHT12 = 2'h0,
    ADCC_RES_RSVD    = 2'h1,
    ADCC_RES_EIGHT   = 2'h2,
    ADCC_RES_LEFT12  = 2'h3
  } adcc_res_t;

  // Finished conversion from the converter core
  typedef struct packed {
    logic        done;
    logic [11:0] conversion_value;
  } adcc_conv_t;

  // Request to the interrupt controller
  typedef struct packed {
    logic       req;
    logic [1:0] irq_priority_level;
  } adcc_irq_t;

endpackage : adcc_pkg

// ==== test/tb_adc_channel_result_irq_scan.sv ====
`timescale 1ns/100ps
module tb_adc_channel_result_irq_scan;
  import adcc_pkg::*;

  // Bench signals
  logic        mclk, rst, avs_read, avs_write, irq_vector_ack;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, rdata0, rdata1;
  logic [3:0]  avs_byteenable, sel0, sel1;
  logic        wreq0, wreq1;
  adcc_conv_t  conv_in;
  adcc_irq_t   irq_out;
  logic [15:0] rd, rd1, thr_m;
  logic [11:0] v;
  int          error_cnt, samples_checked, i, k;
  int          flag_m, lvl_m, mode_m, lay_m, sgn_m, mux_m, off_m, cnt_m;
  int          lays[4] = '{0, 1, 2, 3};

  // Channel zero and a channel without scan sharing one bus
  adcc_channel #(.CHANNEL_INDEX(0)) dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(rdata0), .avs_waitrequest(wreq0),
    .conv_in(conv_in), .applied_input_select(sel0), .irq_out(irq_out),
    .irq_vector_ack(irq_vector_ack));
  adcc_channel #(.CHANNEL_INDEX(1)) dut1 (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(rdata1), .avs_waitrequest(wreq1),
    .conv_in(conv_in), .applied_input_select(sel1), .irq_out(),
    .irq_vector_ack(irq_vector_ack));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [15:0] d);
    int n;
    @(posedge mclk);
    avs_address   <= {idx, 2'b00};
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= {16'h0000, d};
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (wreq0 === 1'b0) break;
    end
    // Data taken and request dropped at the edge that saw waitrequest low
    rd  = rdata0[15:0];
    rd1 = rdata1[15:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n == 20) begin
      error_cnt++;
      summarize();
    end
  endtask

  task automatic rd_chk(input logic [3:0] idx, input int exp);
    bus(1'b0, idx, 16'h0000);
    chk(rd, 16'(exp));
  endtask

  // Bench view of the byte pair for one raw value
  function automatic logic [15:0] fmt(input logic [11:0] x, input int lay, input int s);
    case (lay)
      2: return {{8{s[0] & x[7]}}, x[7:0]};
      3: return {x, 4'h0};
      default: return {{4{s[0] & x[11]}}, x};
    endcase
  endfunction

  // One finished conversion, optionally with a vector ack in the same cycle
  task automatic conv(input logic [11:0] x, input logic ack);
    int cv, tv, hit;
    @(posedge mclk);
    conv_in        <= {1'b1, x};
    irq_vector_ack <= ack;
    @(posedge mclk);
    conv_in.done   <= 1'b0;
    irq_vector_ack <= 1'b0;
    if (lay_m == 2) begin
      if (sgn_m != 0) cv = $signed(x[7:0]);
      else cv = x[7:0];
    end else begin
      if (sgn_m != 0) cv = $signed(x);
      else cv = x;
    end
    if (sgn_m != 0) tv = $signed(thr_m);
    else tv = thr_m;
    hit = (mode_m == 0) || (mode_m == 1 && cv < tv) || (mode_m == 3 && cv > tv);
    if (hit != 0) flag_m = 1;
    else if (ack) flag_m = 0;
    if (cnt_m != 0) off_m = (off_m == cnt_m) ? 0 : off_m + 1;
  endtask

  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h3;
    conv_in = '0;
    irq_vector_ack = 1'b0;
    {flag_m, lvl_m, mode_m, lay_m, sgn_m, mux_m, off_m, cnt_m} = '0;
    thr_m = 16'h0000;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    void'($urandom(32'hffe3));
    // Reset values and an unmapped place
    rd_chk(ADCC_IDX_FLAG, 0);
    rd_chk(ADCC_IDX_CHAN_RESULT_LOW, 0);
    rd_chk(ADCC_IDX_SCAN, 0);
    rd_chk(4'h7, 0);
    chk({15'h0, irq_out.req}, 16'h0000);
    // Random layouts, signs, levels and flag conditions
    for (i = 0; i < 40; i++) begin
      lay_m = lays[$urandom_range(3)];
      sgn_m = $urandom_range(1);
      lvl_m = $urandom_range(3);
      mode_m = (lay_m == 3) ? 0 : $urandom_range(3);
      thr_m = 16'($urandom);
      bus(1'b1, ADCC_IDX_CONFIG, 16'((lay_m << 1) | sgn_m));
      bus(1'b1, ADCC_IDX_INTCTRL, 16'((mode_m << 2) | lvl_m));
      bus(1'b1, ADCC_IDX_THRESH, thr_m);
      v = 12'($urandom);
      conv(v, 1'b0);
      @(negedge mclk);
      chk({15'h0, irq_out.req}, 16'(flag_m != 0 && lvl_m != 0));
      chk({14'h0, irq_out.irq_priority_level}, 16'(lvl_m));
      rd_chk(ADCC_IDX_CHAN_RESULT_LOW, fmt(v, lay_m, sgn_m) & 16'h00ff);
      rd_chk(ADCC_IDX_CHAN_RESULT_HIGH, fmt(v, lay_m, sgn_m) >> 8);
      rd_chk(ADCC_IDX_FLAG, flag_m);
      bus(1'b1, ADCC_IDX_FLAG, 16'h0000);
      rd_chk(ADCC_IDX_FLAG, flag_m);
      if (i % 2 == 1) begin
        bus(1'b1, ADCC_IDX_FLAG, 16'h0001);
      end else begin
        @(posedge mclk);
        irq_vector_ack <= 1'b1;
        @(posedge mclk);
        irq_vector_ack <= 1'b0;
      end
      flag_m = 0;
      rd_chk(ADCC_IDX_FLAG, 0);
    end
    // Flag set and vector ack in the same cycle
    mode_m = 0;
    bus(1'b1, ADCC_IDX_INTCTRL, 16'h0001);
    conv(12'h5a5, 1'b1);
    rd_chk(ADCC_IDX_FLAG, flag_m);
    // A write without the low lane enable is ignored
    avs_byteenable <= 4'h2;
    bus(1'b1, ADCC_IDX_SCAN, 16'h00ff);
    avs_byteenable <= 4'h3;
    rd_chk(ADCC_IDX_SCAN, 0);
    // Scan with the widest, an empty and a random count
    mux_m = $urandom_range(15);
    bus(1'b1, ADCC_IDX_MUXCTRL, 16'(mux_m << 3));
    for (k = 0; k < 3; k++) begin
      cnt_m = (k == 0) ? 15 : (k == 1) ? 0 : $urandom_range(14, 1);
      off_m = 0;
      bus(1'b1, ADCC_IDX_SCAN, 16'(cnt_m));
      repeat (cnt_m + 3) begin
        conv(12'($urandom), 1'b0);
        @(posedge mclk);
        @(negedge mclk);
        chk({12'h0, sel0}, 16'((mux_m + off_m) % 16));
        chk({12'h0, sel1}, 16'(mux_m));
      end
      rd_chk(ADCC_IDX_SCAN, (off_m << 4) | cnt_m);
      chk(rd1, 16'h0000);
    end
    summarize();
  end
endmodule // tb_adc_channel_result_irq_scan
